// >>> bench/ccr_i2c_host.sv
/*
 * I2C controller model standing in for the host processor.
 * Assumes the bench resolves SDA from both open-drain drivers with a pull-up.
 */
module ccr_i2c_host (
    // Clock
    input wire logic clk,
    // Bus
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quarter bit of 25 cycles keeps SCL at 400 kHz
    localparam int QTR = 25;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic q();
        repeat (QTR) @(negedge clk);
    endtask

    task automatic bitio(input logic b, output logic r);
        sda_drv = b;
        q();
        scl = 1'b1;
        q();
        r = sda_line;
        q();
        scl = 1'b0;
        q();
    endtask

    task automatic start();
        sda_drv = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_drv = 1'b0;
        q();
        scl = 1'b0;
        q();
    endtask

    task automatic stop();
        sda_drv = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_drv = 1'b1;
        q();
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic [7:0] r;
        logic n;
        for (int i = 7; i >= 0; i--) bitio(b[i], r[i]);
        bitio(1'b1, n);
        ack = ~n;
    endtask

    task automatic recv(input logic last, output logic [7:0] b);
        logic n;
        for (int i = 7; i >= 0; i--) bitio(1'b1, b[i]);
        bitio(last, n);
    endtask
endmodule

// >>> bench/test_charger_config_register_bank.sv
/*
 * Self-checking bench: I2C traffic through the host model, pins and
 * read-back compared with a register model. Assumes one 40 MHz clock.
 */
module test_charger_config_register_bank;
    import ccr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ssel = 1'b0;
    logic boost = 1'b0;
    logic [2:0] pin_lim = 3'h7;
    logic [1:0] wdp = 2'h0;
    logic [7:0] stat [3];
    logic scl, sda_drv, sda_oe, sda_line, a;
    logic hiz, bst, chg, blim, cold, frc, wdx;
    logic [3:0] vfl, pre, term;
    logic [2:0] ceil, sfl;
    logic [5:0] fcc;
    logic [7:0] mdl [4];
    logic [7:0] rq [$];
    logic [31:0] v;
    int cnt;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 32'h3654;

    always #12.5 clk = ~clk;
    // Pull-up: low if either party pulls
    assign sda_line = sda_drv & ~sda_oe;

    ccr_bank #(.SEC_CYCLES(10)) uut (.clk(clk), .rst(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .source_select_pin(ssel),
        .boost_pin(boost), .detected_source(3'h0), .detect_done(1'b0),
        .external_current_limit_pin(pin_lim), .watchdog_period(wdp), .status_in(stat),
        .input_high_impedance_enable(hiz), .input_voltage_floor(vfl),
        .input_current_ceiling(ceil), .boost_output_enable(bst),
        .battery_charge_enable(chg), .system_voltage_floor(sfl),
        .boost_current_limit(blim), .fast_charge_current(fcc),
        .cold_threshold_select(cold), .precharge_current(pre),
        .termination_current(term), .reduced_charge_current_force(frc),
        .watchdog_expired(wdx));

    ccr_i2c_host host (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$]);
        host.start();
        host.send({TARGET_ADDR, 1'b0}, a);
        chk(a, 1);
        host.send(ptr, a);
        foreach (d[i]) host.send(d[i], a);
        host.stop();
    endtask

    task automatic rd(input logic [7:0] ptr, input int n);
        logic [7:0] b;
        rq = {};
        host.start();
        host.send({TARGET_ADDR, 1'b0}, a);
        host.send(ptr, a);
        host.start();
        host.send({TARGET_ADDR, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            host.recv(i == n - 1, b);
            rq.push_back(b);
        end
        host.stop();
    endtask

    task automatic cmp_regs();
        logic [2:0] m;
        logic [5:0] fc;
        logic [3:0] pc;
        m = (mdl[0][2:0] < pin_lim) ? mdl[0][2:0] : pin_lim;
        fc = mdl[2][0] ? mdl[2][7:2] / 6'h5 : mdl[2][7:2];
        pc = mdl[2][0] ? mdl[3][7:4] >> 1 : mdl[3][7:4];
        rd(8'h00, 4);
        for (int i = 0; i < 4; i++) chk(rq[i], mdl[i]);
        chk({hiz, vfl, ceil}, {mdl[0][7:3], m});
        chk({bst, chg, sfl, blim}, {mdl[1][5], mdl[1][4] & ~mdl[1][5], mdl[1][3:0]});
        chk({fcc, cold, frc}, {fc, mdl[2][1:0]});
        chk({pre, term}, {pc, mdl[3][3:0]});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        stat = '{8'hA5, 8'h3C, 8'h0F};
        // Select strap low at reset: ceiling code 111
        mdl = '{8'h37, 8'h1B, 8'h60, 8'h11};
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        cmp_regs();
        // Neighbouring address must stay silent
        host.start();
        host.send({7'h6A, 1'b0}, a);
        chk(a, 0);
        host.stop();
        for (int k = 0; k < 3; k++) begin
            v = $random(seed);
            mdl[0] = v[7:0];
            mdl[1] = {2'b00, v[13:8]};
            mdl[2] = {v[21:16] % 6'h28, v[23:22]};
            mdl[3] = v[31:24];
            v = $random(seed);
            pin_lim = v[2:0];
            wr(8'h00, {mdl[0], mdl[1], mdl[2], mdl[3]});
            cmp_regs();
        end
        // Status bytes ignore writes
        wr(8'h08, {8'hFF});
        rd(8'h08, 3);
        for (int i = 0; i < 3; i++) chk(rq[i], stat[i]);
        for (int r = 0; r < 3; r++) begin
            ssel = (r != 0);
            boost = (r == 2);
            wr(8'h01, {8'h80});
            mdl = '{{5'h06, ssel ? {1'b0, boost, 1'b0} : 3'h7}, 8'h1B, 8'h60, 8'h11};
            cmp_regs();
        end
        wdp = 2'h1;
        wr(8'h01, {8'h5B});
        cnt = 0;
        while (wdx !== 1'b1 && cnt < 600) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt == 600) begin
            num_errors++;
            final_report();
        end
        // Kick landed 0 to 200 cycles before the stop ended
        chk({cnt >= 200, cnt <= 401}, 2'h3);
        cmp_regs();
        // The read above spaces the kicks far beyond 20 us
        wr(8'h01, {8'h5B});
        chk(wdx, 0);
        wdp = 2'h0;
        final_report();
    end
endmodule

// >>> core/ccr_bank.sv
/*
 * Configuration register bank with I2C target port on open-drain SDA.
 * Assumes SCL and SDA arrive from pins asynchronously and that external
 * pull-ups resolve the bus; the watchdog period field is an input.
 */
module ccr_bank #(
    parameter int SEC_CYCLES = ccr_pkg::SECOND_CYC,
    parameter bit DETECT_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // I2C pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps and detection
    input wire logic source_select_pin,
    input wire logic boost_pin,
    input wire logic [2:0] detected_source,
    input wire logic detect_done,
    input wire logic [2:0] external_current_limit_pin,
    input wire logic [1:0] watchdog_period,
    input wire logic [7:0] status_in [3],
    // Configuration outputs
    output logic input_high_impedance_enable,
    output logic [3:0] input_voltage_floor,
    output logic [2:0] input_current_ceiling,
    output logic boost_output_enable,
    output logic battery_charge_enable,
    output logic [2:0] system_voltage_floor,
    output logic boost_current_limit,
    output logic [5:0] fast_charge_current,
    output logic cold_threshold_select,
    output logic [3:0] precharge_current,
    output logic [3:0] termination_current,
    output logic reduced_charge_current_force,
    output logic watchdog_expired
);
    import ccr_pkg::*;

    typedef enum logic [5:0] {
        CCR_IDLE = 6'h01,
        CCR_ADDR = 6'h02,
        CCR_ACK = 6'h04,
        CCR_WRITE = 6'h08,
        CCR_READ = 6'h10,
        CCR_RACK = 6'h20
    } ccr_state_t;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_d;
        logic sda_d;
        ccr_state_t st;
        logic [3:0] bitn;
        logic [7:0] shreg;
        logic rd;
        logic have_ptr;
        logic [7:0] ptr;
        logic [7:0] r0;
        logic [7:0] r1;
        logic [7:0] r2;
        logic [7:0] r3;
        logic [3:0][7:0] r4to7;
        logic sda_low;
        logic [31:0] wdt_cnt;
        logic [7:0] wdt_sec;
        logic expired;
        logic [2:0] eff_external_current_limit_pin;
        logic chg_out;
        logic [5:0] fast_out;
        logic [3:0] pre_out;
    } ccr_st_t;

    ccr_st_t s;
    ccr_st_t next_s;
    logic [2:0] pin_code;
    logic [7:0] rdata;
    logic [7:0] limit_sec;
    logic scl, sda, scl_rise, scl_fall, start_c, stop_c;

    ////////////////////////////////////////////////////////////////////
    // Default input current code from straps or detection
    always_comb begin
        if (DETECT_VARIANT) begin
            case (detected_source) // [RQ7]
                SRC_DCP_CDP: pin_code = EXTERNAL_CURRENT_LIMIT_PIN_3A;
                SRC_DIV12: pin_code = EXTERNAL_CURRENT_LIMIT_PIN_2A;
                SRC_DIV3: pin_code = EXTERNAL_CURRENT_LIMIT_PIN_1A;
                default: pin_code = boost_pin ? EXTERNAL_CURRENT_LIMIT_PIN_500MA : EXTERNAL_CURRENT_LIMIT_PIN_100MA;
            endcase
        end else if (!source_select_pin) begin
            pin_code = EXTERNAL_CURRENT_LIMIT_PIN_3A; // [RQ6]
        end else begin
            pin_code = boost_pin ? EXTERNAL_CURRENT_LIMIT_PIN_500MA : EXTERNAL_CURRENT_LIMIT_PIN_100MA; // [RQ6]
        end
        case (watchdog_period) // [RQ19]
            2'h1: limit_sec = 8'(WDT_40S_SEC);
            2'h2: limit_sec = 8'(WDT_80S_SEC);
            2'h3: limit_sec = 8'(WDT_160S_SEC);
            default: limit_sec = 8'h00;
        endcase
    end

    always_comb begin
        if (s.ptr == OFS_INPUT_SOURCE) rdata = s.r0;
        else if (s.ptr == OFS_POWER_ON) rdata = s.r1; // Strobes stored as 0 [RQ20]
        else if (s.ptr == OFS_CHARGE_CURRENT) rdata = s.r2;
        else if (s.ptr == OFS_PRECHARGE_TERM) rdata = s.r3;
        else if (s.ptr <= OFS_LAST_RW) rdata = s.r4to7[s.ptr[1:0]];
        else if (s.ptr <= OFS_LAST_RO) rdata = status_in[2'(s.ptr - 8'h08)];
        else rdata = 8'h00;
    end

    assign scl = s.scl_s[1];
    assign sda = s.sda_s[1];
    assign scl_rise = scl && !s.scl_d;
    assign scl_fall = !scl && s.scl_d;
    assign start_c = scl && s.scl_d && !sda && s.sda_d;
    assign stop_c = scl && s.scl_d && sda && !s.sda_d;

    ////////////////////////////////////////////////////////////////////
    // I2C target, register file and watchdog
    always_comb begin
        logic do_reset;
        logic kick;
        do_reset = 1'b0;
        kick = 1'b0;
        next_s = s;
        next_s.scl_s = {s.scl_s[0], scl_in};
        next_s.sda_s = {s.sda_s[0], sda_in};
        next_s.scl_d = scl;
        next_s.sda_d = sda;
        if (start_c) begin
            next_s.st = CCR_ADDR;
            next_s.bitn = 4'h0;
            next_s.have_ptr = 1'b0;
            next_s.sda_low = 1'b0;
        end else if (stop_c) begin
            next_s.st = CCR_IDLE;
            next_s.sda_low = 1'b0;
        end else begin
            case (s.st)
                CCR_ADDR, CCR_WRITE: begin
                    if (scl_rise) begin
                        next_s.shreg = {s.shreg[6:0], sda};
                        next_s.bitn = s.bitn + 4'h1;
                    end
                    if (scl_fall && s.bitn == 4'h8) begin
                        next_s.bitn = 4'h0;
                        if (s.st == CCR_ADDR) begin
                            if (s.shreg[7:1] == TARGET_ADDR) begin // [RQ1]
                                next_s.rd = s.shreg[0];
                                next_s.st = CCR_ACK;
                                next_s.sda_low = 1'b1;
                            end else begin
                                next_s.st = CCR_IDLE;
                            end
                        end else begin
                            next_s.st = CCR_ACK;
                            next_s.sda_low = 1'b1;
                            if (!s.have_ptr) begin
                                next_s.ptr = s.shreg;
                                next_s.have_ptr = 1'b1;
                            end else begin
                                next_s.ptr = s.ptr + 8'h01;
                                if (s.ptr == OFS_INPUT_SOURCE) next_s.r0 = s.shreg;
                                else if (s.ptr == OFS_POWER_ON) begin
                                    next_s.r1 = s.shreg & 8'h3F; // [RQ20]
                                    do_reset = s.shreg[REG_RESET_BIT]; // [RQ8]
                                    kick = s.shreg[WDT_KICK_BIT]; // [RQ9]
                                end
                                else if (s.ptr == OFS_CHARGE_CURRENT) next_s.r2 = s.shreg;
                                else if (s.ptr == OFS_PRECHARGE_TERM) next_s.r3 = s.shreg;
                                else if (s.ptr <= OFS_LAST_RW) begin
                                    next_s.r4to7[s.ptr[1:0]] = s.shreg; // [RQ1]
                                end
                            end
                        end
                    end
                end
                CCR_ACK: begin
                    if (scl_fall) begin
                        if (s.rd) begin
                            next_s.st = CCR_READ;
                            next_s.shreg = rdata;
                            next_s.sda_low = !rdata[7];
                            next_s.bitn = 4'h1;
                        end else begin
                            next_s.st = CCR_WRITE;
                            next_s.sda_low = 1'b0;
                        end
                    end
                end
                CCR_READ: begin
                    if (scl_fall) begin
                        if (s.bitn == 4'h8) begin
                            next_s.st = CCR_RACK;
                            next_s.sda_low = 1'b0;
                            next_s.ptr = s.ptr + 8'h01;
                        end else begin
                            next_s.sda_low = !s.shreg[3'(7 - s.bitn)];
                            next_s.bitn = s.bitn + 4'h1;
                        end
                    end
                end
                CCR_RACK: begin
                    if (scl_rise) next_s.rd = !sda;
                    if (scl_fall) begin
                        if (s.rd) begin
                            next_s.st = CCR_READ;
                            next_s.shreg = rdata;
                            next_s.sda_low = !rdata[7];
                            next_s.bitn = 4'h1;
                        end else begin
                            next_s.st = CCR_IDLE;
                        end
                    end
                end
                default: next_s.st = CCR_IDLE;
            endcase
        end
        if (do_reset) begin // Device mode is untouched, only registers [RQ8]
            next_s.r0 = {RST_INPUT_SOURCE[7:3], pin_code};
            next_s.r1 = RST_POWER_ON;
            next_s.r2 = RST_CHARGE_CURRENT;
            next_s.r3 = RST_PRECHARGE_TERM;
        end else if (DETECT_VARIANT && detect_done) begin
            next_s.r0[2:0] = pin_code; // [RQ7]
        end
        // Watchdog: one-second enable, then seconds count
        if (kick || limit_sec == 8'h00) begin // [RQ9]
            next_s.wdt_cnt = 32'h0;
            next_s.wdt_sec = 8'h00;
            next_s.expired = 1'b0;
        end else if (s.wdt_sec >= limit_sec) begin
            next_s.expired = 1'b1; // [RQ19]
        end else if (s.wdt_cnt == 32'(SEC_CYCLES - 1)) begin
            next_s.wdt_cnt = 32'h0;
            next_s.wdt_sec = s.wdt_sec + 8'h01;
        end else begin
            next_s.wdt_cnt = s.wdt_cnt + 32'h1;
        end
        // Effective settings
        next_s.eff_external_current_limit_pin = (s.r0[2:0] < external_current_limit_pin) ?
            s.r0[2:0] : external_current_limit_pin; // [RQ5]
        next_s.chg_out = s.r1[CHARGE_EN_BIT] && !s.r1[BOOST_EN_BIT]; // [RQ11] [RQ12]
        next_s.fast_out = s.r2[FORCE_BIT] ? 6'((s.r2[7:2] * 1 + 0) / 5) : s.r2[7:2]; // [RQ17]
        next_s.pre_out = s.r2[FORCE_BIT] ? {1'b0, s.r3[7:5]} : s.r3[7:4]; // [RQ17]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.scl_s <= 2'h3;
            s.sda_s <= 2'h3;
            s.scl_d <= 1'b1;
            s.sda_d <= 1'b1;
            s.st <= CCR_IDLE;
            s.r0 <= {RST_INPUT_SOURCE[7:3], pin_code}; // [RQ2] [RQ3] [RQ6]
            s.r1 <= RST_POWER_ON; // [RQ12] [RQ13]
            s.r2 <= RST_CHARGE_CURRENT; // [RQ14] [RQ16]
            s.r3 <= RST_PRECHARGE_TERM; // [RQ18]
            s.chg_out <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = s.sda_low;
    assign input_high_impedance_enable = s.r0[HIZ_BIT]; // [RQ2]
    assign input_voltage_floor = s.r0[6:3]; // [RQ3]
    assign input_current_ceiling = s.eff_external_current_limit_pin; // [RQ4]
    assign boost_output_enable = s.r1[BOOST_EN_BIT];
    assign battery_charge_enable = s.chg_out;
    assign system_voltage_floor = s.r1[3:1]; // [RQ13]
    assign boost_current_limit = s.r1[BOOST_LIM_BIT];
    assign fast_charge_current = s.fast_out; // [RQ14]
    assign cold_threshold_select = s.r2[COLD_SEL_BIT]; // [RQ16]
    assign precharge_current = s.pre_out; // [RQ18]
    assign termination_current = s.r3[3:0]; // [RQ18]
    assign reduced_charge_current_force = s.r2[FORCE_BIT];
    assign watchdog_expired = s.expired;

    a_boost_over_charge: assert property (@(posedge clk) disable iff (rst) // [RQ11]
        s.r1[BOOST_EN_BIT] |=> !battery_charge_enable)
        else $error("charge active while boost enabled");
    a_strobe_reads_zero: assert property (@(posedge clk) disable iff (rst) // [RQ20]
        s.r1[REG_RESET_BIT] == 1'b0 && s.r1[WDT_KICK_BIT] == 1'b0)
        else $error("strobe bit held");
    a_ceiling_min: assert property (@(posedge clk) disable iff (rst) // [RQ5]
        1'b1 |=> input_current_ceiling <= $past(external_current_limit_pin))
        else $error("ceiling above pin limit");
    a_wdt_off_clear: assert property (@(posedge clk) disable iff (rst) // [RQ19]
        watchdog_period == 2'h0 |=> !watchdog_expired)
        else $error("watchdog expired while disabled");
    a_force_scale_down: assert property (@(posedge clk) disable iff (rst) // [RQ17]
        s.r2[FORCE_BIT] |=> fast_charge_current <= $past(s.r2[7:2]))
        else $error("forced charge current not reduced");
    a_idle_bus_free: assert property (@(posedge clk) disable iff (rst) // [RQ1]
        s.st == CCR_IDLE |-> !sda_oe)
        else $error("data line held while idle");
    c_boost: cover property (@(posedge clk) s.r1[BOOST_EN_BIT]);
    c_read: cover property (@(posedge clk) s.st == CCR_READ);
    c_expire: cover property (@(posedge clk) watchdog_expired);
endmodule

// >>> include/ccr_pkg.sv
/*
 * Constants for the charger configuration register bank: I2C target
 * address, register offsets, field positions, reset values, codes.
 * Assumes a single 40 MHz clock domain with synchronous reset.
 */
// Operation
// RQ1 - Answer as I2C target 0x6B; 00-07 read/write, 08-0A read only.
// RQ2 - Input-source bit 7 turns high-impedance input mode on; resets to 0.
// RQ3 - Input-source bits 6:3 set input voltage floor, 3.88V plus 80mV steps; reset 0110.
// RQ4 - Input-source bits 2:0 select the input current ceiling, 100mA to 3A.
// RQ5 - Effective ceiling is the lower of register code and external pin limit.
// RQ6 - Pin variant reset code: 111 if select low, else 000/010 by boost pin.
// RQ7 - Detect variant: SDP 000/010, DCP/CDP 111, divider 1-2 110, divider 3 100.
// RQ8 - Writing 1 to power-on bit 7 restores register defaults, not device mode.
// RQ9 - Writing 1 to power-on bit 6 restarts the host-silence watchdog.
// RQ10 - Host waits at least 20us between two watchdog restarts.
// RQ11 - Boost output enable overrides charge enable, suppressing charging.
// RQ12 - Power-on bit 4 enables battery charging; reset value 1.
// RQ13 - Power-on bits 3:1 set system voltage floor, 3.0V plus 0.1V; reset 101.
// RQ14 - Charge bits 7:2 set fast-charge current, 512mA plus 64mA; reset 011000.
// RQ15 - Host never programs a fast-charge code above the 3008mA code.
// RQ16 - Charge bit 1 picks boost cold threshold 76% or 79% of rail; reset 0.
// RQ17 - Charge bit 0 forces 20% fast-charge and 50% precharge current.
// RQ18 - Precharge bits 7:4 and termination bits 3:0, 128mA steps; reset 0001.
// RQ19 - Watchdog period field: 00 off, 01 40s, 10 80s, 11 160s.
// RQ20 - Register reset and watchdog restart bits self-clear, reading back 0.
package ccr_pkg;
    localparam logic [6:0] TARGET_ADDR = 7'h6B;
    localparam logic [7:0] OFS_INPUT_SOURCE = 8'h00;
    localparam logic [7:0] OFS_POWER_ON = 8'h01;
    localparam logic [7:0] OFS_CHARGE_CURRENT = 8'h02;
    localparam logic [7:0] OFS_PRECHARGE_TERM = 8'h03;
    localparam logic [7:0] OFS_LAST_RW = 8'h07;
    localparam logic [7:0] OFS_LAST_RO = 8'h0A;
    // Reset values; the input current code is filled in from straps or detection
    localparam logic [7:0] RST_INPUT_SOURCE = 8'h30;
    localparam logic [7:0] RST_POWER_ON = 8'h1B;
    localparam logic [7:0] RST_CHARGE_CURRENT = 8'h60;
    localparam logic [7:0] RST_PRECHARGE_TERM = 8'h11;
    // Field positions
    localparam int HIZ_BIT = 7;
    localparam int REG_RESET_BIT = 7;
    localparam int WDT_KICK_BIT = 6;
    localparam int BOOST_EN_BIT = 5;
    localparam int CHARGE_EN_BIT = 4;
    localparam int BOOST_LIM_BIT = 0;
    localparam int COLD_SEL_BIT = 1;
    localparam int FORCE_BIT = 0;
    // Input current codes
    localparam logic [2:0] EXTERNAL_CURRENT_LIMIT_PIN_100MA = 3'h0;
    localparam logic [2:0] EXTERNAL_CURRENT_LIMIT_PIN_500MA = 3'h2;
    localparam logic [2:0] EXTERNAL_CURRENT_LIMIT_PIN_1A = 3'h4;
    localparam logic [2:0] EXTERNAL_CURRENT_LIMIT_PIN_2A = 3'h6;
    localparam logic [2:0] EXTERNAL_CURRENT_LIMIT_PIN_3A = 3'h7;
    // Source detection results
    localparam logic [2:0] SRC_SDP = 3'h0;
    localparam logic [2:0] SRC_DCP_CDP = 3'h1;
    localparam logic [2:0] SRC_DIV12 = 3'h2;
    localparam logic [2:0] SRC_DIV3 = 3'h3;
    // Watchdog periods
    localparam int CLK_HZ = 40_000_000;
    localparam int WDT_40S_SEC = 40;
    localparam int WDT_80S_SEC = 80;
    localparam int WDT_160S_SEC = 160;
    localparam int KICK_GAP_NS = 20_000;
    localparam int KICK_GAP_CYC = (KICK_GAP_NS * 40 + 999) / 1000;
    localparam int SECOND_CYC = CLK_HZ;
endpackage
